// *** sass_cfg.svh ***
// Constants of the simultaneous converter serial sequencer: offsets, fields, counts, times.
// Assumes the sequencer files include it by bare name; definitions only.
`ifndef SASS_CFG_SVH
`define SASS_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define SASS_ADDR_CTRL      32'h0000_0000
`define SASS_ADDR_STATUS    32'h0000_0004
`define SASS_ADDR_LAST      32'h0000_0008
`define SASS_CTRL_RUN_BIT   0
`define SASS_CTRL_CLR_BIT   1
`define SASS_CTRL_RESET     1'h1
`define SASS_ST_STATE       0
`define SASS_ST_LATE        2
`define SASS_ST_REF_RDY     3
`define SASS_ST_RD_ACT      4
`define SASS_ST_BIPOLAR     5
`define SASS_ST_NCHAN       8
`define SASS_ST_LEVEL       12

// ****************************************
// Sequence counts
// ****************************************
`define SASS_CLKS_PER_CHAN  7'h10
`define SASS_LAST_BIT       4'hf
`define SASS_MAX_CHANS      3'h6
`define SASS_NAP_PULSES     3'h2
`define SASS_SLEEP_PULSES   3'h4
`define SASS_FIFO_DEPTH     4

// ****************************************
// Times
// ****************************************
// Clock period 5000 ps, strobe setup 3000 ps, reference settling 2 ms.
`define SASS_CLK_PERIOD_PS  64'h0000_0000_0000_1388
`define SASS_SETUP_PS       64'h0000_0000_0000_0bb8
`define SASS_REF_SETTLE_MS  64'h0000_0000_0000_0002
`define SASS_PS_PER_MS      64'h0000_0000_3b9a_ca00
`define SASS_SETUP_CYC \
   ((`SASS_SETUP_PS + `SASS_CLK_PERIOD_PS - 64'h1) / `SASS_CLK_PERIOD_PS)
`define SASS_REF_SETTLE_CYC \
   (`SASS_REF_SETTLE_MS * `SASS_PS_PER_MS / `SASS_CLK_PERIOD_PS)

`endif

// *** sass_pkg.sv ***
// Types shared by the serial sequencer files.
// Assumes nothing of its surroundings.
`default_nettype none
package sass_pkg;
   typedef enum logic [1:0] {SASS_ACQUIRE, SASS_CONVERT, SASS_NAP, SASS_SLEEP} sass_state_e;
   typedef logic [11:0] sass_code_t;
   typedef logic [15:0] sass_word_t;
endpackage
`default_nettype wire

// *** sass_fifo.sv ***
// Small result FIFO with registered read data and valid/ready on both sides.
// Assumes one clock; DEPTH at least two.
`timescale 1ns/1ps
`default_nettype none
module sass_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 4
) (
   // Clock and reset.
   input  wire logic                       hclk,
   input  wire logic                       hresetn,
   // Filling side.
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   // Draining side.
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic      [WIDTH-1:0]           out_data,
   // Occupancy.
   output logic      [$clog2(DEPTH+1)-1:0] level
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0]    wr_ptr_reg, wr_ptr_next;
   logic [PW-1:0]    rd_ptr_reg, rd_ptr_next;
   logic [CW-1:0]    count_reg, count_next;
   logic [WIDTH-1:0] data_reg, data_next;
   logic             push;
   logic             pop;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   always_comb begin
      in_ready    = (count_reg != CW'(DEPTH));
      out_valid   = (count_reg != '0);
      push        = in_valid & in_ready;
      pop         = out_valid & out_ready;
      wr_ptr_next = push ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
      rd_ptr_next = pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
      count_next  = CW'(count_reg + CW'(push) - CW'(pop));
      // A word written into the slot about to be read bypasses the array.
      if (push && (wr_ptr_reg == rd_ptr_next)) begin
         data_next = in_data;
      end else begin
         data_next = mem_reg[rd_ptr_next];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
         data_reg   <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg  <= count_next;
         data_reg   <= data_next;
      end
   end

   always_ff @(posedge hclk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   assign out_data = data_reg;
   assign level    = count_reg;
endmodule
`default_nettype wire

// *** sass_top.sv ***
// Conversion and readout sequencer of a six-channel simultaneous sampling converter.
// Assumes an AHB-Lite master on hclk, asynchronous host pins, and a converter core on hclk.
`timescale 1ns/1ps
`include "sass_cfg.svh"
`default_nettype none
module sass_top #(
   parameter logic [18:0] REF_SETTLE_CYC = 19'(`SASS_REF_SETTLE_CYC),
   parameter int          FIFO_DEPTH     = `SASS_FIFO_DEPTH
) (
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Host pins.
   input  wire logic        sck,
   input  wire logic        convert_strobe,
   input  wire logic        chan_count_sel_msb,
   input  wire logic        chan_count_sel_mid,
   input  wire logic        chan_count_sel_lsb,
   input  wire logic        bipolar_select,
   output logic             sdo,
   output logic             sdo_oe,
   // Converter core.
   output logic             core_start,
   output logic             core_hold,
   output logic             core_nap,
   output logic             core_sleep,
   output logic      [2:0]  core_chan_count,
   input  wire logic [11:0] core_result,
   input  wire logic        core_result_valid,
   output logic             core_result_ready
);
   localparam logic [7:0] SETUP_CYC = 8'(`SASS_SETUP_CYC);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [5:0] pin_s1_reg, pin_s2_reg;
   logic [1:0] edge_reg;
   logic       sck_rise, strb_rise, bipolar_sync;
   logic [2:0] sel_sync;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         edge_reg   <= '0;
      end else begin
         pin_s1_reg <= {sck, convert_strobe, chan_count_sel_msb, chan_count_sel_mid,
                        chan_count_sel_lsb, bipolar_select};
         pin_s2_reg <= pin_s1_reg;
         edge_reg   <= pin_s2_reg[5:4];
      end
   end

   assign sck_rise  = pin_s2_reg[5] & ~edge_reg[1];
   assign strb_rise = pin_s2_reg[4] & ~edge_reg[0];
   assign sel_sync  = pin_s2_reg[3:1];
   assign bipolar_sync = pin_s2_reg[0];

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [2:0] chan_count(input logic [2:0] sel);
      chan_count = (sel >= 3'h5) ? `SASS_MAX_CHANS : 3'(sel + 3'h1);
   endfunction

   function automatic sass_pkg::sass_word_t load_word(input logic ok, input sass_pkg::sass_code_t c,
                                                      input logic bipolar);
      sass_pkg::sass_code_t k;
      k         = bipolar ? {~c[11], c[10:0]} : c;
      load_word = ok ? {k, 4'h0} : '0;
   endfunction

   // ****************************************
   // Result FIFO
   // ****************************************
   logic                 fifo_valid, fifo_pop;
   sass_pkg::sass_code_t fifo_data;
   logic [2:0]           fifo_level;

   sass_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_fifo (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .in_valid  (core_result_valid),
      .in_ready  (core_result_ready),
      .in_data   (core_result),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data),
      .level     (fifo_level)
   );

   // ****************************************
   // Register slave
   // ****************************************
   logic        accept, run_reg, run_next, clr_late;
   logic        wr_pend_reg, wr_pend_next;
   logic [31:0] wr_addr_reg, wr_addr_next, hrdata_reg, hrdata_next, status;
   logic        late_reg, late_next;
   logic        rd_active_reg, rd_active_next;
   logic [18:0] ref_reg, ref_next;
   logic [2:0]  n_chan_reg, n_chan_next;
   logic        bipolar_reg, bipolar_next;
   sass_pkg::sass_state_e state_reg, state_next;
   sass_pkg::sass_word_t  last_reg, last_next;

   always_comb begin
      accept       = hsel & hready & htrans[1] & (hsize == 3'h2);
      wr_pend_next = accept & hwrite;
      wr_addr_next = accept ? haddr : wr_addr_reg;
      run_next     = run_reg;
      clr_late     = 1'b0;
      if (wr_pend_reg && (wr_addr_reg == `SASS_ADDR_CTRL)) begin
         run_next = hwdata[`SASS_CTRL_RUN_BIT];
         clr_late = hwdata[`SASS_CTRL_CLR_BIT];
      end
      status                          = '0;
      status[`SASS_ST_STATE +: 2]     = state_reg;
      status[`SASS_ST_LATE]           = late_reg;
      status[`SASS_ST_REF_RDY]        = (ref_reg == '0);
      status[`SASS_ST_RD_ACT]         = rd_active_reg;
      status[`SASS_ST_BIPOLAR]        = bipolar_reg;
      status[`SASS_ST_NCHAN +: 3]     = n_chan_reg;
      status[`SASS_ST_LEVEL +: 3]     = fifo_level;
      hrdata_next = hrdata_reg;
      if (accept && !hwrite) begin
         if (haddr == `SASS_ADDR_CTRL) begin
            hrdata_next = {31'h0, run_reg};
         end else if (haddr == `SASS_ADDR_STATUS) begin
            hrdata_next = status;
         end else if (haddr == `SASS_ADDR_LAST) begin
            hrdata_next = {16'h0, last_reg};
         end else begin
            hrdata_next = '0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
         run_reg     <= `SASS_CTRL_RESET;
         hrdata_reg  <= '0;
      end else begin
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         run_reg     <= run_next;
         hrdata_reg  <= hrdata_next;
      end
   end

   assign hrdata    = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ****************************************
   // Conversion sequencer
   // ****************************************
   logic [6:0] clk_cnt_reg, clk_cnt_next, total_clks;
   logic [2:0] pulse_reg, pulse_next;
   logic       start, start_reg;

   assign total_clks = 7'(`SASS_CLKS_PER_CHAN * {4'h0, n_chan_reg});

   always_comb begin
      state_next   = state_reg;
      clk_cnt_next = clk_cnt_reg;
      pulse_next   = pulse_reg;
      n_chan_next  = n_chan_reg;
      bipolar_next = bipolar_reg;
      ref_next     = (ref_reg != '0) ? 19'(ref_reg - 19'h1) : ref_reg;
      start        = 1'b0;
      case (state_reg)
         sass_pkg::SASS_ACQUIRE: begin
            if (sck_rise) begin
               pulse_next = '0;
            end
            if (strb_rise && run_reg) begin
               start        = 1'b1;
               state_next   = sass_pkg::SASS_CONVERT;
               pulse_next   = 3'h1;
               clk_cnt_next = sck_rise ? 7'h01 : 7'h00;
               n_chan_next  = chan_count(sel_sync);
               bipolar_next = bipolar_sync;
            end
         end
         sass_pkg::SASS_CONVERT: begin
            if (sck_rise) begin
               pulse_next   = '0;
               clk_cnt_next = 7'(clk_cnt_reg + 7'h1);
               if (clk_cnt_reg == 7'(total_clks - 7'h1)) begin
                  state_next = sass_pkg::SASS_ACQUIRE;
               end
            end else if (strb_rise) begin
               pulse_next = 3'(pulse_reg + 3'h1);
               if (3'(pulse_reg + 3'h1) == `SASS_NAP_PULSES) begin
                  state_next = sass_pkg::SASS_NAP;
               end
            end
         end
         sass_pkg::SASS_NAP: begin
            if (sck_rise) begin
               state_next = sass_pkg::SASS_ACQUIRE;
               pulse_next = '0;
            end else if (strb_rise) begin
               pulse_next = 3'(pulse_reg + 3'h1);
               if (3'(pulse_reg + 3'h1) == `SASS_SLEEP_PULSES) begin
                  state_next = sass_pkg::SASS_SLEEP;
               end
            end
         end
         sass_pkg::SASS_SLEEP: begin
            if (sck_rise) begin
               state_next = sass_pkg::SASS_ACQUIRE;
               pulse_next = '0;
               ref_next   = REF_SETTLE_CYC;
            end
         end
         default: begin
            state_next = sass_pkg::SASS_ACQUIRE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg   <= sass_pkg::SASS_ACQUIRE;
         clk_cnt_reg <= '0;
         pulse_reg   <= '0;
         n_chan_reg  <= `SASS_MAX_CHANS;
         bipolar_reg <= 1'b0;
         ref_reg     <= '0;
         start_reg   <= 1'b0;
      end else begin
         state_reg   <= state_next;
         clk_cnt_reg <= clk_cnt_next;
         pulse_reg   <= pulse_next;
         n_chan_reg  <= n_chan_next;
         bipolar_reg <= bipolar_next;
         ref_reg     <= ref_next;
         start_reg   <= start;
      end
   end

   // Inputs are held while converting; the hold is released in acquire, nap and sleep.
   assign core_start      = start_reg;
   assign core_hold       = (state_reg == sass_pkg::SASS_CONVERT);
   assign core_nap        = (state_reg == sass_pkg::SASS_NAP);
   assign core_sleep      = (state_reg == sass_pkg::SASS_SLEEP);
   assign core_chan_count = n_chan_reg;

   // ****************************************
   // Readout shifter
   // ****************************************
   sass_pkg::sass_word_t rd_word_reg, rd_word_next;
   logic [3:0] rd_bit_reg, rd_bit_next;
   logic [2:0] rd_chan_reg, rd_chan_next;
   logic [7:0] setup_reg, setup_next;
   logic       first_reg, first_next;

   // Readout advances only on clock edges, so a slow host clock is harmless.
   always_comb begin
      rd_word_next   = rd_word_reg;
      rd_bit_next    = rd_bit_reg;
      rd_chan_next   = rd_chan_reg;
      rd_active_next = rd_active_reg;
      last_next      = last_reg;
      first_next     = first_reg;
      fifo_pop       = 1'b0;
      late_next      = clr_late ? 1'b0 : late_reg;
      setup_next     = (setup_reg != 8'hff) ? 8'(setup_reg + 8'h1) : setup_reg;
      if (start) begin
         rd_word_next   = load_word(fifo_valid, fifo_data, bipolar_sync);
         last_next      = rd_word_next;
         fifo_pop       = fifo_valid;
         rd_bit_next    = '0;
         rd_chan_next   = '0;
         rd_active_next = 1'b1;
         first_next     = 1'b1;
         setup_next     = 8'h01;
         if (sck_rise) begin
            late_next = 1'b1;
         end
      end else if (state_next == sass_pkg::SASS_NAP) begin
         rd_active_next = 1'b0;
      end else if (sck_rise && rd_active_reg) begin
         first_next = 1'b0;
         if (first_reg && (setup_reg < SETUP_CYC)) begin
            late_next = 1'b1;
         end else if (rd_bit_reg == `SASS_LAST_BIT) begin
            rd_bit_next = '0;
            if (rd_chan_reg == 3'(n_chan_reg - 3'h1)) begin
               rd_active_next = 1'b0;
            end else begin
               rd_word_next = load_word(fifo_valid, fifo_data, bipolar_reg);
               last_next    = rd_word_next;
               fifo_pop     = fifo_valid;
               rd_chan_next = 3'(rd_chan_reg + 3'h1);
            end
         end else begin
            rd_word_next = {rd_word_reg[14:0], 1'b0};
            rd_bit_next  = 4'(rd_bit_reg + 4'h1);
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_word_reg   <= '0;
         rd_bit_reg    <= '0;
         rd_chan_reg   <= '0;
         rd_active_reg <= 1'b0;
         last_reg      <= '0;
         first_reg     <= 1'b0;
         late_reg      <= 1'b0;
         setup_reg     <= 8'hff;
      end else begin
         rd_word_reg   <= rd_word_next;
         rd_bit_reg    <= rd_bit_next;
         rd_chan_reg   <= rd_chan_next;
         rd_active_reg <= rd_active_next;
         last_reg      <= last_next;
         first_reg     <= first_next;
         late_reg      <= late_next;
         setup_reg     <= setup_next;
      end
   end

   assign sdo    = rd_word_reg[15];
   assign sdo_oe = rd_active_reg;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_frame_count_end: assert property ((state_reg == sass_pkg::SASS_CONVERT) && sck_rise
      && (clk_cnt_reg == 7'(total_clks - 7'h1)) |=> (state_reg == sass_pkg::SASS_ACQUIRE))
      else $error("Conversion did not end after its last clock.");
   a_frame_count_max: assert property ((state_reg == sass_pkg::SASS_CONVERT) |->
      (clk_cnt_reg < total_clks) && (total_clks <= 7'h60))
      else $error("Conversion clock count out of range.");
   a_strobe_holds: assert property ((state_reg == sass_pkg::SASS_ACQUIRE) && strb_rise
      && run_reg |=> core_hold && core_start ##1 !core_start)
      else $error("Strobe rise did not hold the inputs.");
   a_late_flag: assert property (start && sck_rise |=> late_reg && sdo_oe ##1
      $stable(rd_word_reg) || !sck_rise)
      else $error("Short setup did not delay the data.");
   a_sel_latch: assert property (start |=> (n_chan_reg == chan_count($past(sel_sync))))
      else $error("Channel count not taken from the select inputs.");
   a_bipolar_code: assert property (start && fifo_valid && bipolar_sync |=>
      (rd_word_reg[15] == ~$past(fifo_data[11])) && (rd_word_reg[3:0] == 4'h0))
      else $error("Bipolar coding wrong.");
   a_idle_stable: assert property (rd_active_reg && !sck_rise && !strb_rise |=>
      $stable(rd_word_reg))
      else $error("Readout moved without a clock edge.");
   a_release: assert property (rd_active_reg && sck_rise && !start && !first_reg
      && (rd_bit_reg == `SASS_LAST_BIT) && (rd_chan_reg == 3'(n_chan_reg - 3'h1)) |=> !sdo_oe)
      else $error("Output not released after the last bit.");
   a_nap_entry: assert property ((state_reg == sass_pkg::SASS_CONVERT) && strb_rise
      && !sck_rise && (pulse_reg == 3'h1) |=> (state_reg == sass_pkg::SASS_NAP) && !sdo_oe)
      else $error("Second static pulse did not nap.");
   a_sleep_entry: assert property ((state_reg == sass_pkg::SASS_NAP) && strb_rise
      && !sck_rise && (pulse_reg == 3'h3) |=> (state_reg == sass_pkg::SASS_SLEEP))
      else $error("Fourth static pulse did not sleep.");
   a_nap_wake: assert property ((state_reg == sass_pkg::SASS_NAP) && sck_rise |=>
      (state_reg == sass_pkg::SASS_ACQUIRE) && (pulse_reg == 3'h0))
      else $error("Clock did not wake from nap.");
   a_sleep_wake: assert property ((state_reg == sass_pkg::SASS_SLEEP) && sck_rise |=>
      (state_reg == sass_pkg::SASS_ACQUIRE) && (ref_reg == REF_SETTLE_CYC))
      else $error("Clock did not wake from sleep.");

   c_full_frame: cover property ((state_reg == sass_pkg::SASS_CONVERT) && (n_chan_reg == 3'h6)
      ##1 (state_reg == sass_pkg::SASS_ACQUIRE));
   c_late: cover property (start && sck_rise);
   c_sleep: cover property ((state_reg == sass_pkg::SASS_SLEEP) ##1 sck_rise);
   c_fifo_full: cover property (!core_result_ready);
endmodule
`default_nettype wire

// *** sass_host_model.sv ***
// Host model: drives the strobe and the serial clock, captures the serial line.
// Assumes the bench's hclk; pin times are counted in hclk cycles.
`timescale 1ns/1ps
`default_nettype none
module sass_host_model (
   // Clock.
   input  wire logic        hclk,
   // Host pins.
   input  wire logic        sdo,
   input  wire logic        sdo_oe,
   output logic             sck,
   output logic             convert_strobe
);
   logic        line;
   logic [95:0] bits;
   // A released line shows the inverse level, so stale data cannot pass.
   assign line = sdo_oe ? sdo : ~sdo;
   initial begin
      sck = 1'b0;
      convert_strobe = 1'b0;
      bits = '0;
   end
   task automatic pulse();
      convert_strobe <= 1'b1;
      repeat (4) @(posedge hclk);
      convert_strobe <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask
   task automatic start();
      repeat (800) @(posedge hclk);
      pulse();
   endtask
   task automatic late_start();
      convert_strobe <= 1'b1;
      sck <= 1'b1;
      repeat (4) @(posedge hclk);
      convert_strobe <= 1'b0;
      sck <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask
   // One rise also wakes from nap or sleep.
   task automatic clock_bits(input int n, input int half);
      for (int i = 0; i < n; i++) begin
         sck <= 1'b1;
         bits = {bits[94:0], line};
         repeat (half) @(posedge hclk);
         sck <= 1'b0;
         repeat (half) @(posedge hclk);
      end
   endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Bench of the serial sequencer: bus reads, host frames and core pushes.
// Assumes the sequencer, its FIFO and the host model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, bipolar, sdo, sdo_oe, sck, strobe;
   logic core_start, core_hold, core_nap, core_sleep, cvalid, cready;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [2:0]  hsize, sel, cnt;
   logic [1:0]  htrans;
   logic [11:0] code;
   logic [95:0] e;
   int          n, miscompares, n_tests, n_start;
   sass_top #(.REF_SETTLE_CYC(19'h32), .FIFO_DEPTH(4)) DUT (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .sck(sck), .convert_strobe(strobe), .chan_count_sel_msb(sel[2]),
      .chan_count_sel_mid(sel[1]), .chan_count_sel_lsb(sel[0]), .bipolar_select(bipolar),
      .sdo(sdo), .sdo_oe(sdo_oe), .core_start(core_start), .core_hold(core_hold),
      .core_nap(core_nap), .core_sleep(core_sleep), .core_chan_count(cnt),
      .core_result(code), .core_result_valid(cvalid), .core_result_ready(cready));
   sass_host_model u_host (.hclk(hclk), .sdo(sdo), .sdo_oe(sdo_oe), .sck(sck),
      .convert_strobe(strobe));
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   // Every accepted strobe must give exactly one start pulse to the core.
   always @(posedge hclk) begin
      if (core_start === 1'b1) n_start++;
   end
   task automatic chk(input string name, input logic [95:0] seen, input logic [95:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      hsize <= 3'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask
   task automatic rd(input string name, input logic [31:0] a, m, exp);
      ahb(1'b0, a, 32'h0);
      chk(name, q & m, exp);
   endtask
   task automatic push(input logic [11:0] c);
      code <= c;
      cvalid <= 1'b1;
      @(posedge hclk);
      while (cready !== 1'b1) @(posedge hclk);
      cvalid <= 1'b0;
      @(posedge hclk);
   endtask
   task automatic test_done();
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge hclk);
      miscompares++;
      test_done();
   end
   initial begin
      {hresetn, hsel, hwrite, bipolar, cvalid, sel, hsize, htrans, code, haddr, hwdata} = '0;
      e = '0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd("ctrl", 32'h0, 32'h3, 32'h1);
      chk("resp", hresp, 1'b0);
      rd("unmapped", 32'h10, '1, 32'h0);
      for (int i = 0; i < 4; i++) begin
         push(12'ha53 + 12'(i) * 12'h111);
         e = {e[79:0], 12'ha53 + 12'(i) * 12'h111, 4'h0};
      end
      chk("full", cready, 1'b0);
      rd("level", 32'h4, 32'h7000, 32'h4000);
      sel <= 3'h3;
      u_host.start();
      rd("nchan", 32'h4, 32'h703, 32'h401);
      u_host.clock_bits(64, 4);
      chk("data", u_host.bits[63:0], e[63:0]);
      push(12'h7f0);
      sel <= 3'h0;
      bipolar <= 1'b1;
      u_host.start();
      u_host.clock_bits(16, 40);
      chk("bipolar", u_host.bits[15:0], 16'hff00);
      rd("last", 32'h8, 32'hffff, 32'hff00);
      bipolar <= 1'b0;
      for (int c = 0; c < 8; c++) begin
         n = (c > 5) ? 6 : c + 1;
         sel <= c[2:0];
         u_host.start();
         chk("hold", core_hold, 1'b1);
         rd("nchan", 32'h4, 32'h703, {n[2:0], 8'h01});
         chk("cnt", cnt, n[2:0]);
         u_host.clock_bits(16 * n - 1, 4);
         chk("oe_on", sdo_oe, 1'b1);
         u_host.clock_bits(1, 4);
         chk("oe_off", sdo_oe, 1'b0);
         rd("acq", 32'h4, 32'h3, 32'h0);
      end
      u_host.pulse();
      u_host.pulse();
      rd("nap", 32'h4, 32'h3, 32'h2);
      chk("nap_pin", core_nap, 1'b1);
      u_host.clock_bits(1, 4);
      rd("wake", 32'h4, 32'h3, 32'h0);
      repeat (4) u_host.pulse();
      rd("sleep", 32'h4, 32'h3, 32'h3);
      chk("sleep_pin", core_sleep, 1'b1);
      u_host.clock_bits(1, 4);
      rd("ref_wait", 32'h4, 32'hb, 32'h0);
      repeat (60) @(posedge hclk);
      rd("ref_ok", 32'h4, 32'hb, 32'h8);
      sel <= 3'h0;
      push(12'h5a5);
      u_host.late_start();
      rd("late", 32'h4, 32'h4, 32'h4);
      u_host.clock_bits(15, 4);
      chk("late_on", sdo_oe, 1'b1);
      u_host.clock_bits(1, 4);
      chk("late_off", sdo_oe, 1'b0);
      chk("late_data", u_host.bits[15:0], 16'h5a50);
      ahb(1'b1, 32'h0, 32'h3);
      rd("clr", 32'h4, 32'h4, 32'h0);
      chk("starts", n_start, 32'd13);
      test_done();
   end
endmodule
`default_nettype wire
